// ===== logic/fhp_dev.sv
/*
  Flash end of the dual host bus port: hub nibble protocol and
  multiplexed-address programmer port, feeding a command write path
  and taking a read byte from the array side.
  Assumes pins are asynchronous and pass fhp_sync; the array side
  answers rd_data combinationally from rd_addr.
*/
`timescale 1ns/1ps
`include "fhp_regs.svh"
module fhp_dev
  import fhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fhp_bus_if.dev bus,
  input wire logic [3:0] id_strap_inputs,
  input wire logic [7:0] rd_data,
  input wire logic pe_busy,
  output logic [27:0] rd_addr,
  output logic cmd_we,
  output logic [27:0] cmd_addr,
  output logic [7:0] cmd_data,
  output logic pe_abort,
  output logic blocks_unprotected,
  output logic extras_enabled
);
  localparam int SW = 4 + 1 + 1 + 1 + `FHP_ROW_W + 1 + 1 + 1 + 8;
  logic [SW-1:0] s_q;
  logic [3:0] nib_s;
  logic frm_s, mode_s, rst_s, rc_s, oe_n_s, st_n_s;
  logic [`FHP_ROW_W-1:0] ad_s;
  logic [7:0] dq_s;
  fhp_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({bus.nibble_bus, bus.frame_strobe, bus.hub_nibble_mode,
        bus.interface_reset_n, bus.addr_pins, bus.row_column_select,
        bus.output_enable_n, bus.store_strobe_n, bus.data_pins}),
    .q(s_q)
  );
  assign {nib_s, frm_s, mode_s, rst_s, ad_s, rc_s, oe_n_s, st_n_s, dq_s}
    = s_q;

  fhp_phase_t ph_r, ph_nxt;
  logic wr_r, wr_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [27:0] ha_r, ha_nxt;
  logic [7:0] hd_r, hd_nxt;
  logic [3:0] no_r, no_nxt;
  logic noe_r, noe_nxt;
  logic [`FHP_ROW_W-1:0] row_r, row_nxt;
  logic [`FHP_COL_W-1:0] col_r, col_nxt;
  logic rc_d_r, st_d_r, rc_d_nxt, st_d_nxt;
  logic [7:0] do_r, do_nxt;
  logic doe_r, doe_nxt;
  logic we_r, we_nxt, ab_r, ab_nxt;
  logic [27:0] ca_r, ca_nxt;
  logic [7:0] cd_r, cd_nxt;
  logic [27:0] ra_r, ra_nxt;
  logic [19:0] pa;

  assign pa = {col_r, row_r};

  // Next state of both front ends and the shared command path.
  always_comb
  begin
    ph_nxt = ph_r;
    wr_nxt = wr_r;
    cnt_nxt = cnt_r;
    ha_nxt = ha_r;
    hd_nxt = hd_r;
    no_nxt = `FHP_TAR;
    noe_nxt = 1'b0;
    row_nxt = row_r;
    col_nxt = col_r;
    rc_d_nxt = rc_s;
    st_d_nxt = st_n_s;
    do_nxt = do_r;
    doe_nxt = 1'b0;
    we_nxt = 1'b0;
    ab_nxt = 1'b0;
    ca_nxt = ca_r;
    cd_nxt = cd_r;
    ra_nxt = ra_r;
    if (!rst_s)
    begin
      ph_nxt = FHP_IDLE;
      ab_nxt = pe_busy;
    end
    else if (mode_s)
    begin
      if (!frm_s)
      begin
        // Frame low restarts the decode and releases the bus.
        cnt_nxt = `FHP_ZERO_3;
        if (nib_s == `FHP_START_READ)
        begin
          ph_nxt = FHP_TGT;
          wr_nxt = 1'b0;
        end
        else if (nib_s == `FHP_START_WRITE)
        begin
          ph_nxt = FHP_TGT;
          wr_nxt = 1'b1;
        end
        else
          ph_nxt = FHP_SKIP;
      end
      else
      begin
        case (ph_r)
          FHP_TGT:
            ph_nxt = (nib_s == id_strap_inputs) ? FHP_ADDR : FHP_SKIP;
          FHP_ADDR:
          begin
            ha_nxt = {ha_r[23:0], nib_s};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == `FHP_ADDR_NIBBLES - 3'h1)
              ph_nxt = FHP_SIZE;
          end
          FHP_SIZE:
          begin
            cnt_nxt = `FHP_ZERO_3;
            ra_nxt = ha_r;
            if (nib_s != `FHP_SIZE_BYTE)
              ph_nxt = FHP_SKIP;
            else
              ph_nxt = wr_r ? FHP_WDATA : FHP_HTAR;
          end
          FHP_WDATA:
          begin
            hd_nxt = {nib_s, hd_r[7:4]};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r != `FHP_ZERO_3)
              ph_nxt = FHP_HTAR;
          end
          FHP_HTAR:
          begin
            ph_nxt = FHP_DTAR;
            noe_nxt = 1'b1;
          end
          FHP_DTAR:
          begin
            noe_nxt = 1'b1;
            cnt_nxt = `FHP_ZERO_3;
            if (wr_r)
            begin
              ph_nxt = FHP_ACK;
              no_nxt = `FHP_READY;
              we_nxt = 1'b1;
              ca_nxt = ha_r;
              cd_nxt = hd_r;
            end
            else
            begin
              ph_nxt = FHP_WAITS;
              no_nxt = `FHP_WAIT;
            end
          end
          FHP_WAITS:
          begin
            noe_nxt = 1'b1;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == {2'b00, `FHP_WAIT_CYCLES})
            begin
              ph_nxt = FHP_RDY;
              no_nxt = `FHP_READY;
              hd_nxt = rd_data;
            end
            else
              no_nxt = `FHP_WAIT;
          end
          FHP_RDY:
          begin
            noe_nxt = 1'b1;
            ph_nxt = FHP_RDATA;
            cnt_nxt = `FHP_ZERO_3;
            no_nxt = hd_r[3:0];
          end
          FHP_RDATA:
          begin
            noe_nxt = 1'b1;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == `FHP_ZERO_3)
              no_nxt = hd_r[7:4];
            else
              ph_nxt = FHP_ETAR;
          end
          FHP_ACK:
          begin
            noe_nxt = 1'b1;
            ph_nxt = FHP_ETAR;
          end
          FHP_ETAR:
            ph_nxt = FHP_IDLE;
          FHP_SKIP:
            ph_nxt = FHP_SKIP;
          FHP_IDLE:
            ph_nxt = FHP_IDLE;
          default:
            ph_nxt = FHP_IDLE;
        endcase
      end
    end
    else
    begin
      ph_nxt = FHP_IDLE;
      // Row half on select fall, column half on select rise.
      if (rc_d_r && !rc_s)
        row_nxt = ad_s;
      if (!rc_d_r && rc_s)
        col_nxt = ad_s[`FHP_COL_W-1:0];
      // Store rising edge hands data to the command path.
      if (!st_d_r && st_n_s && oe_n_s)
      begin
        we_nxt = 1'b1;
        ca_nxt = {8'h00, pa};
        cd_nxt = dq_s;
      end
      if (!oe_n_s && st_n_s)
      begin
        doe_nxt = 1'b1;
        ra_nxt = {8'h00, pa};
        do_nxt = rd_data;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_r <= FHP_IDLE;
      wr_r <= 1'b0;
      cnt_r <= `FHP_ZERO_3;
      ha_r <= `FHP_ZERO_28;
      hd_r <= `FHP_ZERO_8;
      no_r <= `FHP_TAR;
      noe_r <= 1'b0;
      row_r <= '0;
      col_r <= '0;
      rc_d_r <= 1'b0;
      st_d_r <= 1'b1;
      do_r <= `FHP_ZERO_8;
      doe_r <= 1'b0;
      we_r <= 1'b0;
      ab_r <= 1'b0;
      ca_r <= `FHP_ZERO_28;
      cd_r <= `FHP_ZERO_8;
      ra_r <= `FHP_ZERO_28;
    end
    else
    begin
      ph_r <= ph_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
      ha_r <= ha_nxt;
      hd_r <= hd_nxt;
      no_r <= no_nxt;
      noe_r <= noe_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      rc_d_r <= rc_d_nxt;
      st_d_r <= st_d_nxt;
      do_r <= do_nxt;
      doe_r <= doe_nxt;
      we_r <= we_nxt;
      ab_r <= ab_nxt;
      ca_r <= ca_nxt;
      cd_r <= cd_nxt;
      ra_r <= ra_nxt;
    end
  end

  // Mode flags registered; programmer mode drops protection and extras.
  logic unp_r, ext_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unp_r <= 1'b0;
      ext_r <= 1'b0;
    end
    else
    begin
      unp_r <= !mode_s;
      ext_r <= mode_s;
    end
  end

  assign bus.nib_dev_o = no_r;
  assign bus.nib_dev_oe = noe_r;
  assign bus.data_dev_o = do_r;
  assign bus.data_dev_oe = doe_r;
  assign rd_addr = ra_r;
  assign cmd_we = we_r;
  assign cmd_addr = ca_r;
  assign cmd_data = cd_r;
  assign pe_abort = ab_r;
  assign blocks_unprotected = unp_r;
  assign extras_enabled = ext_r;
endmodule : fhp_dev

// ===== logic/fhp_regs.svh
/*
  Constants for the flash dual host bus port: pin codes, cycle counts,
  field positions and reset values.
  Assumes it is included by bare name by every file that needs them.
*/
// How it works
// - Start nibble 1101b with frame low: read.
// - Start nibble 1110b with frame low: write.
// - Next nibble must equal strapped id.
// - Seven address nibbles, most significant first.
// - Size field is always 0000b.
// - Host drives 1111b, device takes next cycle.
// - Read: device sends 0101b two cycles.
// - Then 0000b one cycle, data next.
// - Read byte: low nibble, then high nibble.
// - Write byte follows size, low nibble first.
// - Write: device sends 0000b acknowledge once.
// - Device ends with 1111b, then floats.
// - Programmer mode: every block unprotected.
// - Programmer mode: commands only, no extras.
// - Programmer address comes in two halves.
// - Store high, output enable low: drive byte.
// - Store rising edge captures data pins.
// - Output enable high: data pins float.
// - Interface reset low: deselect, float all.
// - Reset during program aborts, cells invalid.
// - Zero address returns maker/device code.
// - Low half on select fall, high on rise.
// - Frame low mid transfer aborts, floats bus.
`ifndef FHP_REGS_SVH
`define FHP_REGS_SVH
`define FHP_START_READ 4'hD
`define FHP_START_WRITE 4'hE
`define FHP_SIZE_BYTE 4'h0
`define FHP_TAR 4'hF
`define FHP_WAIT 4'h5
`define FHP_READY 4'h0
`define FHP_ADDR_NIBBLES 3'h7
`define FHP_WAIT_CYCLES 1'h1
`define FHP_ROW_W 11
`define FHP_COL_W 9
`define FHP_SIG_ADDR_HI 19
`define FHP_ZERO_20 20'h00000
`define FHP_ZERO_28 28'h0000000
`define FHP_ZERO_8 8'h00
`define FHP_ZERO_4 4'h0
`define FHP_ZERO_3 3'h0
`endif

// ===== logic/fhp_pkg.sv
/*
  Types shared by both ends of the flash dual host bus port.
  Assumes fhp_regs.svh holds the numeric constants.
*/
package fhp_pkg;
  // Phases of a hub transfer as seen on the nibble bus.
  typedef enum logic [3:0] {
    FHP_IDLE, FHP_TGT, FHP_ADDR, FHP_SIZE, FHP_WDATA, FHP_HTAR,
    FHP_DTAR, FHP_WAITS, FHP_RDY, FHP_RDATA, FHP_ACK, FHP_ETAR, FHP_SKIP
  } fhp_phase_t;
endpackage : fhp_pkg

// ===== logic/fhp_bus_if.sv
/*
  Pin bundle between flash port and its host or programmer.
  Each shared wire is resolved here from the enables, device side first.
*/
`timescale 1ns/1ps
`include "fhp_regs.svh"
interface fhp_bus_if;
  logic [3:0] nib_host_o;
  logic nib_host_oe;
  logic [3:0] nib_dev_o;
  logic nib_dev_oe;
  logic [3:0] nibble_bus;
  logic frame_strobe;
  logic hub_nibble_mode;
  logic interface_reset_n;
  logic [`FHP_ROW_W-1:0] addr_pins;
  logic row_column_select;
  logic output_enable_n;
  logic store_strobe_n;
  logic [7:0] data_host_o;
  logic data_host_oe;
  logic [7:0] data_dev_o;
  logic data_dev_oe;
  logic [7:0] data_pins;
  // Wire resolution: whoever enables drives, else bus idles high.
  assign nibble_bus = nib_dev_oe ? nib_dev_o :
                      (nib_host_oe ? nib_host_o : 4'hF);
  assign data_pins = data_dev_oe ? data_dev_o :
                     (data_host_oe ? data_host_o : 8'hFF);
  modport dev (
    input nibble_bus, frame_strobe, hub_nibble_mode, interface_reset_n,
    input addr_pins, row_column_select, output_enable_n, store_strobe_n,
    input data_pins,
    output nib_dev_o, nib_dev_oe, data_dev_o, data_dev_oe
  );
  modport host (
    input nibble_bus, data_pins,
    output nib_host_o, nib_host_oe, frame_strobe, hub_nibble_mode,
    output interface_reset_n, addr_pins, row_column_select,
    output output_enable_n, store_strobe_n, data_host_o, data_host_oe
  );
endinterface : fhp_bus_if

// ===== logic/fhp_sync.sv
/*
  Two flip-flop synchroniser for a bundle of pin levels.
  Assumes the inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module fhp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // First stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : fhp_sync

// ===== logic/fhp_host.sv
/*
  Chipset end of the hub nibble bus: issues single-byte reads and
  writes on request and returns the read byte.
  Assumes the device answers nibbles on the same clock; the nibble
  bus input is sampled through fhp_sync, so answers are seen late.
*/
`timescale 1ns/1ps
`include "fhp_regs.svh"
module fhp_host
  import fhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fhp_bus_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic [3:0] req_target,
  input wire logic [27:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  logic [3:0] nib_s;
  fhp_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(bus.nibble_bus),
    .q(nib_s)
  );
  fhp_phase_t ph_r, ph_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [3:0] tg_r, tg_nxt, o_r, o_nxt;
  logic [27:0] a_r, a_nxt;
  logic [7:0] d_r, d_nxt, rd_r, rd_nxt;
  logic oe_r, oe_nxt, fr_r, fr_nxt, bz_r, bz_nxt, dn_r, dn_nxt;

  // Host drives start, target, address, size, data and turnaround.
  always_comb
  begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r + 5'h01;
    wr_nxt = wr_r;
    tg_nxt = tg_r;
    a_nxt = a_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    o_nxt = `FHP_TAR;
    oe_nxt = 1'b1;
    fr_nxt = 1'b1;
    bz_nxt = 1'b1;
    dn_nxt = 1'b0;
    case (ph_r)
      FHP_IDLE:
      begin
        bz_nxt = req;
        if (req)
        begin
          ph_nxt = FHP_TGT;
          fr_nxt = 1'b0;
          o_nxt = req_write ? `FHP_START_WRITE : `FHP_START_READ;
          wr_nxt = req_write;
          tg_nxt = req_target;
          a_nxt = req_addr;
          d_nxt = req_wdata;
        end
      end
      FHP_TGT:
      begin
        o_nxt = tg_r;
        ph_nxt = FHP_ADDR;
        cnt_nxt = 5'h00;
      end
      FHP_ADDR:
      begin
        o_nxt = a_r[27:24];
        a_nxt = {a_r[23:0], `FHP_ZERO_4};
        if (cnt_r[2:0] == `FHP_ADDR_NIBBLES - 3'h1)
          ph_nxt = FHP_SIZE;
      end
      FHP_SIZE:
      begin
        o_nxt = `FHP_SIZE_BYTE;
        ph_nxt = wr_r ? FHP_WDATA : FHP_HTAR;
        cnt_nxt = 5'h00;
      end
      FHP_WDATA:
      begin
        o_nxt = d_r[3:0];
        d_nxt = {`FHP_ZERO_4, d_r[7:4]};
        if (cnt_r != 5'h00)
          ph_nxt = FHP_HTAR;
      end
      FHP_HTAR:
      begin
        o_nxt = `FHP_TAR;
        ph_nxt = FHP_DTAR;
        cnt_nxt = 5'h00;
      end
      FHP_DTAR:
      begin
        // Released bus: watch the synced nibbles for the answer.
        oe_nxt = 1'b0;
        if (cnt_r > 5'h01 && nib_s == `FHP_READY)
        begin
          ph_nxt = wr_r ? FHP_ETAR : FHP_RDATA;
          cnt_nxt = 5'h00;
        end
        else if (cnt_r == 5'h1F)
          ph_nxt = FHP_ETAR;
      end
      FHP_RDATA:
      begin
        oe_nxt = 1'b0;
        rd_nxt = {nib_s, rd_r[7:4]};
        if (cnt_r != 5'h00)
          ph_nxt = FHP_ETAR;
      end
      FHP_ETAR:
      begin
        oe_nxt = 1'b0;
        if (cnt_r[1])
        begin
          ph_nxt = FHP_IDLE;
          oe_nxt = 1'b1;
          dn_nxt = 1'b1;
          bz_nxt = 1'b0;
        end
      end
      default:
        ph_nxt = FHP_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_r <= FHP_IDLE;
      cnt_r <= 5'h00;
      wr_r <= 1'b0;
      tg_r <= `FHP_ZERO_4;
      a_r <= `FHP_ZERO_28;
      d_r <= `FHP_ZERO_8;
      rd_r <= `FHP_ZERO_8;
      o_r <= `FHP_TAR;
      oe_r <= 1'b0;
      fr_r <= 1'b1;
      bz_r <= 1'b0;
      dn_r <= 1'b0;
    end
    else
    begin
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      tg_r <= tg_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
      o_r <= o_nxt;
      oe_r <= oe_nxt;
      fr_r <= fr_nxt;
      bz_r <= bz_nxt;
      dn_r <= dn_nxt;
    end
  end

  assign bus.nib_host_o = o_r;
  assign bus.nib_host_oe = oe_r;
  assign bus.frame_strobe = fr_r;
  assign bus.hub_nibble_mode = 1'b1;
  assign bus.interface_reset_n = rst_n;
  assign bus.addr_pins = '0;
  assign bus.row_column_select = 1'b1;
  assign bus.output_enable_n = 1'b1;
  assign bus.store_strobe_n = 1'b1;
  assign bus.data_host_o = `FHP_ZERO_8;
  assign bus.data_host_oe = 1'b0;
  assign busy = bz_r;
  assign done = dn_r;
  assign rdata = rd_r;
endmodule : fhp_host

// ===== test/fhp_asserts.sv
/*
  Concurrent checks on the hub nibble bus between host and device.
  Assumes it watches the first interface, where both ends are design code.
*/
`timescale 1ns/1ps
module fhp_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] nib_dev_o,
  input wire logic nib_dev_oe,
  input wire logic nib_host_oe,
  input wire logic [3:0] nibble_bus,
  input wire logic frame_strobe
);
  logic [3:0] oe_cnt_r;
  logic [3:0] oe_cnt_nxt;

  // Counts how many cycles in a row the device has held the bus.
  always_comb
  begin
    oe_cnt_nxt = nib_dev_oe ? oe_cnt_r + 4'h1 : 4'h0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_cnt_r <= 4'h0;
    else
      oe_cnt_r <= oe_cnt_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_no_clash: assert property (!(nib_dev_oe && nib_host_oe))
    else $error("both ends drive the nibble bus");
  a_tar_first: assert property ($rose(nib_dev_oe) |-> nib_dev_o == 4'hF)
    else $error("device did not open with a turnaround nibble");
  a_start_code: assert property (!frame_strobe |->
    nibble_bus == 4'hD || nibble_bus == 4'hE)
    else $error("frame low without a start code");
  a_host_tar: assert property ($fell(nib_host_oe) |->
    $past(nibble_bus) == 4'hF)
    else $error("host released without a turnaround nibble");
  a_read_sync: assert property ($rose(nib_dev_oe) ##1 nib_dev_o == 4'h5
    |=> nib_dev_o == 4'h5 ##1 nib_dev_o == 4'h0 ##1 nib_dev_oe)
    else $error("wait and ready pattern wrong");
  a_read_end: assert property ($rose(nib_dev_oe) ##1 nib_dev_o == 4'h5
    ##1 nib_dev_o == 4'h5 ##1 nib_dev_o == 4'h0 |-> ##1 nib_dev_oe
    ##1 nib_dev_oe ##1 nibble_bus == 4'hF ##[0:1] !nib_dev_oe)
    else $error("read did not end after two data nibbles");
  a_write_ack: assert property ($rose(nib_dev_oe)
    ##1 (nib_dev_oe && nib_dev_o == 4'h0)
    |=> nibble_bus == 4'hF ##[0:1] !nib_dev_oe)
    else $error("write acknowledge not followed by release");
  a_oe_bound: assert property (oe_cnt_r <= 4'h7)
    else $error("device held the bus too long");
  a_frame_abort: assert property ($fell(frame_strobe) |->
    ##[0:4] !nib_dev_oe)
    else $error("device kept the bus after frame low");
endmodule : fhp_asserts

// ===== test/testbench.sv
/*
  Self-checking bench: host and device joined on one bus, and a second
  device driven directly for programmer mode, aborts and faults.
  Assumes the logic/ files and fhp_asserts are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] ID = 4'hB;
  localparam logic [7:0] MAKER_CODE = 8'hA5; // Arbitrary value.
  localparam logic [7:0] DEVICE_CODE = 8'h3C; // Arbitrary value.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [3:0] req_target = 4'h0;
  logic [27:0] req_addr = 28'h0000000;
  logic [7:0] req_wdata = 8'h00;
  logic busy, done, cmd_we1, cmd_we2, pe_abort2, bu1, bu2, ee1, ee2;
  logic [7:0] rdata, rd_data1, rd_data2, cmd_data1, cmd_data2;
  logic [27:0] rd_addr1, rd_addr2, cmd_addr1, cmd_addr2;
  logic pe_busy2 = 1'b0;
  logic [15:0] seed = 16'h2152;
  logic [35:0] wq[$];
  logic [35:0] wq2[$];
  logic [3:0] dq[$];
  logic [3:0] hq[$];
  int mismatches = 0;
  int comparisons = 0;
  int aborts = 0;
  int k;

  fhp_bus_if bus1 ();
  fhp_bus_if bus2 ();

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Array model: two signature bytes at the bottom, a hash elsewhere.
  function automatic logic [7:0] mem(input logic [27:0] a);
    if (a == 28'h0000000)
      return MAKER_CODE;
    if (a == 28'h0000001)
      return DEVICE_CODE;
    return a[7:0] ^ a[15:8] ^ a[27:20] ^ 8'h5A;
  endfunction : mem

  assign rd_data1 = mem(rd_addr1);
  assign rd_data2 = mem(rd_addr2);

  always #2.5 clk = ~clk;

  fhp_host fhp_host_inst (.clk(clk), .rst_n(rst_n), .bus(bus1.host),
    .req(req), .req_write(req_write), .req_target(req_target),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata));
  fhp_dev fhp_dev_inst (.clk(clk), .rst_n(rst_n), .bus(bus1.dev),
    .id_strap_inputs(ID), .rd_data(rd_data1), .pe_busy(1'b0),
    .rd_addr(rd_addr1), .cmd_we(cmd_we1), .cmd_addr(cmd_addr1),
    .cmd_data(cmd_data1), .pe_abort(), .blocks_unprotected(bu1),
    .extras_enabled(ee1));
  fhp_dev fhp_dev_inst2 (.clk(clk), .rst_n(rst_n), .bus(bus2.dev),
    .id_strap_inputs(ID), .rd_data(rd_data2), .pe_busy(pe_busy2),
    .rd_addr(rd_addr2), .cmd_we(cmd_we2), .cmd_addr(cmd_addr2),
    .cmd_data(cmd_data2), .pe_abort(pe_abort2), .blocks_unprotected(bu2),
    .extras_enabled(ee2));
  fhp_asserts fhp_asserts_inst (.clk(clk), .rst_n(rst_n),
    .nib_dev_o(bus1.nib_dev_o), .nib_dev_oe(bus1.nib_dev_oe),
    .nib_host_oe(bus1.nib_host_oe), .nibble_bus(bus1.nibble_bus),
    .frame_strobe(bus1.frame_strobe));

  // Records command writes, device nibbles and host header nibbles.
  always @(posedge clk)
  begin
    if (cmd_we1)
      wq.push_back({cmd_addr1, cmd_data1});
    if (cmd_we2)
      wq2.push_back({cmd_addr2, cmd_data2});
    if (bus1.nib_dev_oe)
      dq.push_back(bus1.nibble_bus);
    if (!bus1.frame_strobe)
      hq = {bus1.nibble_bus};
    else if (hq.size() > 0 && hq.size() < 12)
      hq.push_back(bus1.nibble_bus);
    if (pe_abort2)
      aborts++;
  end

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (!ok)
    begin
      mismatches++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // One hub transfer through the host, checked against the model.
  task automatic hub(input logic wr, input logic [3:0] tgt);
    logic [27:0] a;
    logic [27:0] got;
    logic [7:0] d;
    logic [7:0] e;
    int n;
    seed = lfsr(seed);
    a = {seed[11:0], seed};
    seed = lfsr(seed);
    d = seed[7:0];
    e = mem(a);
    dq.delete();
    wq.delete();
    @(posedge clk);
    req <= 1'b1;
    req_write <= wr;
    req_target <= tgt;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    for (n = 0; n < 80 && done !== 1'b1; n++)
      @(negedge clk);
    if (n == 80)
    begin
      mismatches++;
      close_out();
    end
    repeat (4) @(negedge clk);
    check(busy === 1'b0, "busy after done");
    for (n = 2; n < 9; n++)
      got = {got[23:0], hq[n]};
    check(hq.size() == 12 && hq[0] === (wr ? 4'hE : 4'hD), "start");
    check(hq[1] === tgt && got === a && hq[9] === 4'h0, "header");
    if (tgt != ID)
      check(dq.size() == 0 && wq.size() == 0, "foreign id");
    else if (wr)
    begin
      check(hq[10] === d[3:0] && hq[11] === d[7:4], "wdata");
      check(wq.size() == 1 && wq[0] === {a, d}, "cmd");
      check(dq.size() >= 2 && dq[0] === 4'hF && dq[1] === 4'h0, "ack");
    end
    else
    begin
      check(rdata === e && rd_addr1 === a && wq.size() == 0, "rd");
      check(dq.size() >= 6 && dq[1] === 4'h5 && dq[2] === 4'h5, "wait");
      check(dq[3] === 4'h0 && dq[4] === e[3:0] && dq[5] === e[7:4], "dat");
    end
  endtask : hub

  // Hand-driven hub header on the second bus, then wait for the device.
  task automatic hdr2(input logic [3:0] s);
    @(posedge clk);
    bus2.frame_strobe <= 1'b0;
    bus2.nib_host_o <= s;
    @(posedge clk);
    bus2.frame_strobe <= 1'b1;
    bus2.nib_host_o <= ID;
    // Seven address nibbles and the size field, then the turnaround.
    repeat (8)
    begin
      @(posedge clk);
      bus2.nib_host_o <= 4'h0;
    end
    @(posedge clk);
    bus2.nib_host_o <= 4'hF;
    @(posedge clk);
    bus2.nib_host_oe <= 1'b0;
    for (k = 0; k < 12 && bus2.nib_dev_oe !== 1'b1; k++)
      @(negedge clk);
  endtask : hdr2

  // Programmer access: row on select fall, column on rise, then data.
  task automatic prog(input logic wr, input logic [10:0] row,
    input logic [8:0] col);
    logic [7:0] d;
    seed = lfsr(seed);
    d = seed[7:0];
    wq2.delete();
    @(posedge clk);
    bus2.addr_pins <= row;
    @(posedge clk);
    bus2.row_column_select <= 1'b0;
    repeat (4) @(posedge clk);
    bus2.addr_pins <= {2'b00, col};
    @(posedge clk);
    bus2.row_column_select <= 1'b1;
    repeat (4) @(posedge clk);
    if (wr)
    begin
      bus2.data_host_o <= d;
      bus2.data_host_oe <= 1'b1;
      @(posedge clk);
      bus2.store_strobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      bus2.store_strobe_n <= 1'b1;
      repeat (6) @(posedge clk);
      bus2.data_host_oe <= 1'b0;
      check(wq2.size() == 1 && wq2[0] === {8'h00, col, row, d}, "st");
    end
    else
    begin
      bus2.output_enable_n <= 1'b0;
      repeat (6) @(negedge clk);
      d = mem({8'h00, col, row});
      check(bus2.data_dev_oe === 1'b1 && bus2.data_pins === d, "rd");
      @(posedge clk);
      bus2.output_enable_n <= 1'b1;
      repeat (6) @(negedge clk);
      check(bus2.data_dev_oe === 1'b0 && wq2.size() == 0, "float");
    end
  endtask : prog

  // Main sequence.
  initial
  begin
    bus2.nib_host_o = 4'hF;
    bus2.nib_host_oe = 1'b1;
    bus2.frame_strobe = 1'b1;
    bus2.hub_nibble_mode = 1'b1;
    bus2.interface_reset_n = 1'b0;
    bus2.addr_pins = 11'h000;
    bus2.row_column_select = 1'b1;
    bus2.output_enable_n = 1'b1;
    bus2.store_strobe_n = 1'b1;
    bus2.data_host_o = 8'h00;
    bus2.data_host_oe = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus2.interface_reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    check(bu1 === 1'b0 && ee1 === 1'b1, "hub flags");
    for (int i = 0; i < 12; i++)
      hub(i[0], ID);
    hub(1'b1, ID ^ 4'h1);
    hub(1'b0, ID ^ 4'h2);
    hdr2(4'h3);
    check(k == 12, "bad start answered");
    @(posedge clk);
    bus2.nib_host_oe <= 1'b1;
    hdr2(4'hD);
    check(k < 12, "no answer to read");
    @(posedge clk);
    bus2.frame_strobe <= 1'b0;
    @(posedge clk);
    bus2.frame_strobe <= 1'b1;
    repeat (5) @(negedge clk);
    check(bus2.nib_dev_oe === 1'b0, "abort kept bus");
    @(posedge clk);
    bus2.nib_host_oe <= 1'b1;
    bus2.hub_nibble_mode <= 1'b0;
    repeat (6) @(negedge clk);
    check(bu2 === 1'b1 && ee2 === 1'b0, "prog flags");
    prog(1'b0, 11'h000, 9'h000);
    prog(1'b0, 11'h001, 9'h000);
    for (int i = 0; i < 4; i++)
      prog(i[0], seed[10:0], seed[15:7]);
    pe_busy2 <= 1'b1;
    bus2.output_enable_n <= 1'b0;
    repeat (6) @(posedge clk);
    bus2.interface_reset_n <= 1'b0;
    repeat (6) @(negedge clk);
    check(bus2.data_dev_oe === 1'b0 && aborts > 0, "reset");
    close_out();
  end
endmodule : testbench
